/* File: pkg/rfid_head_pkg.sv */
// constants shared by the read/write head object set
// assumes one 100 MHz clock and an object-dictionary access port
//
// Overview of operation
// - a tag read sets read error 0x00 ok, 0x01 no answer, 0x02 bad answer.
// - each tag write sets a separate write error with the same codes.
// - each tag access sets tag error 0x00 for none, 0x0F for any other.
// - tag error 0x01 unsupported, 0x02 malformed, 0x03 bad option.
// - tag error 0x10 no section, 0x11 locked again, 0x12 locked content.
// - tag error 0x13 program verify fail, 0x14 lock verify fail.
// - writing 0 to antenna enable turns the field off; no tag is seen.
// - writing 1 to antenna enable switches the field on again.
// - the type selection takes codes 1 to 13 only, code 1 user-defined.
// - supported types read at tag info sub-indices 0x01 to 0x0D; 0x0E to 0xFE read zero.
// - the tag type selection defaults to code 2.
// - the type is stored non-volatile only on the master's save trigger.
// - tag information objects read zero while no tag is detected, except sub-index 0 of 0x2180.
// - extended tag info is fetched only on the master's request.
// - strength reads 0 with no tag, else 1 weakest to 8 strongest.
package rfid_head_pkg;
  // object indices
  localparam logic [15:0] IDX_DEVICE_STATUS = 16'h2150;
  localparam logic [15:0] IDX_ANTENNA_ENABLE = 16'h2151;
  localparam logic [15:0] IDX_TAG_TYPE_SELECT = 16'h2161;
  localparam logic [15:0] IDX_SIGNAL_STRENGTH = 16'h2162;
  localparam logic [15:0] IDX_TAG_INFO = 16'h2180;
  localparam logic [15:0] IDX_TAG_INFO_EXT = 16'h2182;
  localparam logic [15:0] IDX_UID_LOW = 16'h2190;
  localparam logic [15:0] IDX_UID_HIGH = 16'h2191;
  localparam logic [15:0] IDX_SAVE_PARAM = 16'h1010;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_SAVE_ALL = 8'h01;
  localparam logic [7:0] SUB_LIST_FIRST = 8'h01;
  localparam logic [7:0] SUB_LIST_LAST = 8'hFE;
  localparam logic [7:0] SUB_EXT_FIRST = 8'h01;
  localparam logic [7:0] SUB_EXT_LAST = 8'h08;
  localparam logic [31:0] SAVE_SIGNATURE = 32'h65766173;
  // tag type codes
  localparam logic [7:0] TYPE_MIN = 8'h01;
  localparam logic [7:0] TYPE_MAX = 8'h0D;
  localparam logic [7:0] TYPE_DEFAULT = 8'h02;
  // access result codes, shared by read and write
  localparam logic [7:0] ACC_OK = 8'h00;
  localparam logic [7:0] ACC_NO_ANSWER = 8'h01;
  localparam logic [7:0] ACC_RX_FAULT = 8'h02;
  // tag-side error codes
  localparam logic [7:0] TERR_NONE = 8'h00;
  localparam logic [7:0] TERR_CMD_UNSUPPORTED = 8'h01;
  localparam logic [7:0] TERR_MALFORMED = 8'h02;
  localparam logic [7:0] TERR_BAD_OPTION = 8'h03;
  localparam logic [7:0] TERR_OTHER = 8'h0F;
  localparam logic [7:0] TERR_SECTION_UNUSABLE = 8'h10;
  localparam logic [7:0] TERR_SECTION_LOCKED = 8'h11;
  localparam logic [7:0] TERR_SECTION_FROZEN = 8'h12;
  localparam logic [7:0] TERR_PROGRAM_VERIFY = 8'h13;
  localparam logic [7:0] TERR_LOCK_VERIFY = 8'h14;
  // signal strength range
  localparam logic [7:0] LEVEL_NONE = 8'h00;
  localparam logic [7:0] LEVEL_MIN = 8'h01;
  localparam logic [7:0] LEVEL_MAX = 8'h08;
  // device status layout
  localparam int ST_POW = 0;
  localparam int ST_ANT = 1;
  localparam int ST_PRESENT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_READ_LSB = 8;
  localparam int ST_WRITE_LSB = 16;
  localparam int ST_TAG_LSB = 24;
  localparam logic ANTENNA_RESET = 1'b1;
  // front-end outcome of one tag access
  typedef enum logic [1:0] {
    OUTCOME_OK,
    OUTCOME_NO_ANSWER,
    OUTCOME_RX_FAULT
  } outcome_t;
endpackage

/* File: design/rfid_head_objects.sv */
// object set of the read/write head: errors, antenna, type, info, strength
// assumes the front end and object access port run on clk; one request
// at a time, answered exactly one cycle later
module rfid_head_objects #(
  parameter int EXT_BYTES = 8 // bytes of extended tag information
) (
  input wire logic clk, // 100 MHz clock
  input wire logic nrst, // asynchronous reset, active low
  // object dictionary access
  input wire logic od_req, // one-cycle request
  input wire logic od_write, // 1 write, 0 read
  input wire logic [15:0] od_index, // object index
  input wire logic [7:0] od_subindex, // object sub-index
  input wire logic [31:0] od_wdata, // write value
  output logic od_ack, // one-cycle answer
  output logic od_abort, // answer refuses the access
  output logic [31:0] od_rdata, // read value
  // transponder front end
  input wire logic tag_seen, // level, tag detected in field
  input wire logic front_busy, // level, tag access running
  input wire logic acc_done, // pulse, tag access finished
  input wire logic acc_is_write, // finished access was a write
  input wire rfid_head_pkg::outcome_t acc_outcome, // result of access
  input wire logic [7:0] acc_tag_code, // error code sent by tag
  input wire logic [3:0] strength_raw, // raw level, 0..15
  input wire logic [63:0] tag_uid, // uid of tag in field
  input wire logic ext_done, // pulse, extended info fetched
  input wire logic [8*EXT_BYTES-1:0] ext_data, // fetched bytes
  output logic ext_fetch_req, // pulse, fetch extended info
  output logic field_on, // level, antenna field enabled
  output logic [7:0] access_type, // type governing memory access
  // persistent storage
  input wire logic nv_type_valid, // stored type present
  input wire logic [7:0] nv_type, // stored type value
  output logic nv_save_req, // pulse, store nv_save_type
  output logic [7:0] nv_save_type // value to store
);
  import rfid_head_pkg::*;

  initial begin
    if (EXT_BYTES < 6 || EXT_BYTES > 8) begin
      $error("EXT_BYTES must lie in 6..8");
    end
  end

  localparam logic [7:0] EXT_SUB_LAST = 8'(EXT_BYTES);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] tag_code_class(input logic [7:0] code);
    unique case (code)
      TERR_NONE, TERR_CMD_UNSUPPORTED, TERR_MALFORMED, TERR_BAD_OPTION,
      TERR_SECTION_UNUSABLE, TERR_SECTION_LOCKED, TERR_SECTION_FROZEN,
      TERR_PROGRAM_VERIFY, TERR_LOCK_VERIFY:
        tag_code_class = code;
      default:
        tag_code_class = TERR_OTHER;
    endcase
  endfunction

  function automatic logic [7:0] outcome_code(input outcome_t o);
    unique case (o)
      OUTCOME_OK: outcome_code = ACC_OK;
      OUTCOME_NO_ANSWER: outcome_code = ACC_NO_ANSWER;
      OUTCOME_RX_FAULT: outcome_code = ACC_RX_FAULT;
      default: outcome_code = ACC_RX_FAULT;
    endcase
  endfunction

  function automatic logic type_legal(input logic [31:0] v);
    type_legal = (v >= 32'(TYPE_MIN)) && (v <= 32'(TYPE_MAX));
  endfunction

  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub);
    hit = (od_index == idx) && (od_subindex == sub);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic antenna_enable_reg;
  logic [7:0] tag_type_select_reg;
  logic [7:0] signal_strength_level_reg;
  logic [7:0] read_err_reg;
  logic [7:0] write_err_reg;
  logic [7:0] tag_err_reg;
  logic present_reg;
  logic nv_loaded_reg;
  logic ext_valid_reg;
  logic [8*EXT_BYTES-1:0] ext_reg;
  logic ext_pending_reg;
  logic od_ack_reg;
  logic od_abort_reg;
  logic [31:0] od_rdata_reg;
  logic ext_fetch_req_reg;
  logic nv_save_req_reg;
  logic [7:0] nv_save_type_reg;

  logic present_next;
  logic wr_antenna;
  logic wr_type;
  logic wr_save;
  logic wr_fetch;
  logic write_ok;
  logic [31:0] read_value;
  logic read_ok;

  // the field counts as empty whenever the antenna is off
  assign present_next = tag_seen && antenna_enable_reg;

  ////////////////////////////////////////////////////////////////////////
  // write decode

  always_comb begin
    wr_antenna = 1'b0;
    wr_type = 1'b0;
    wr_save = 1'b0;
    wr_fetch = 1'b0;
    write_ok = 1'b0;
    if (od_req && od_write) begin
      if (hit(IDX_ANTENNA_ENABLE, SUB_ZERO)) begin
        // only off and on mean anything; other values are refused
        wr_antenna = (od_wdata <= 32'h0000_0001);
        write_ok = wr_antenna;
      end else if (hit(IDX_TAG_TYPE_SELECT, SUB_ZERO)) begin
        wr_type = type_legal(od_wdata);
        write_ok = wr_type;
      end else if (hit(IDX_SAVE_PARAM, SUB_SAVE_ALL)) begin
        wr_save = (od_wdata == SAVE_SIGNATURE);
        write_ok = wr_save;
      end else if (hit(IDX_TAG_INFO_EXT, SUB_ZERO)) begin
        // a fetch without a tag would only time out in the front end
        wr_fetch = present_reg;
        write_ok = wr_fetch;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode

  always_comb begin
    read_value = 32'h0000_0000;
    read_ok = 1'b1;
    if (hit(IDX_DEVICE_STATUS, SUB_ZERO)) begin
      // busy is taken live so a poll sees a running access
      read_value[ST_POW] = 1'b1;
      read_value[ST_ANT] = antenna_enable_reg;
      read_value[ST_PRESENT] = present_reg;
      read_value[ST_BUSY] = front_busy;
      read_value[ST_READ_LSB +: 8] = read_err_reg;
      read_value[ST_WRITE_LSB +: 8] = write_err_reg;
      read_value[ST_TAG_LSB +: 8] = tag_err_reg;
    end else if (hit(IDX_ANTENNA_ENABLE, SUB_ZERO)) begin
      read_value = {31'h0000_0000, antenna_enable_reg};
    end else if (hit(IDX_TAG_TYPE_SELECT, SUB_ZERO)) begin
      read_value = {24'h00_0000, tag_type_select_reg};
    end else if (hit(IDX_SIGNAL_STRENGTH, SUB_ZERO)) begin
      read_value = {24'h00_0000, signal_strength_level_reg};
    end else if (od_index == IDX_TAG_INFO) begin
      if (od_subindex == SUB_ZERO) begin
        read_value = {24'h00_0000, SUB_LIST_LAST};
      end else if (od_subindex <= SUB_LIST_LAST) begin
        // entry n lists type code n up to TYPE_MAX; zero above it or without a tag
        if (present_reg && od_subindex <= TYPE_MAX) begin
          read_value = {24'h00_0000, od_subindex};
        end
      end else begin
        read_ok = 1'b0;
      end
    end else if (od_index == IDX_TAG_INFO_EXT) begin
      if (od_subindex >= SUB_EXT_FIRST && od_subindex <= EXT_SUB_LAST) begin
        if (ext_valid_reg) begin
          read_value = {24'h00_0000,
            ext_reg[8*(od_subindex - SUB_EXT_FIRST) +: 8]};
        end
      end else if (od_subindex != SUB_ZERO) begin
        read_ok = 1'b0;
      end
    end else if (hit(IDX_UID_LOW, SUB_ZERO)) begin
      read_value = present_reg ? tag_uid[31:0] : 32'h0000_0000;
    end else if (hit(IDX_UID_HIGH, SUB_ZERO)) begin
      read_value = present_reg ? tag_uid[63:32] : 32'h0000_0000;
    end else begin
      read_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access answer, always one cycle after the request

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      od_ack_reg <= 1'b0;
      od_abort_reg <= 1'b0;
      od_rdata_reg <= 32'h0000_0000;
    end else begin
      od_ack_reg <= od_req;
      od_abort_reg <= od_req && (od_write ? !write_ok : !read_ok);
      if (od_req && !od_write && read_ok) begin
        od_rdata_reg <= read_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // antenna field

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      antenna_enable_reg <= ANTENNA_RESET;
    end else if (wr_antenna) begin
      antenna_enable_reg <= od_wdata[0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      present_reg <= 1'b0;
    end else begin
      present_reg <= present_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tag type: default, then stored value caught once after reset

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tag_type_select_reg <= TYPE_DEFAULT;
      nv_loaded_reg <= 1'b0;
    end else begin
      nv_loaded_reg <= 1'b1;
      if (wr_type) begin
        tag_type_select_reg <= od_wdata[7:0];
      end else if (!nv_loaded_reg && nv_type_valid &&
                   type_legal({24'h00_0000, nv_type})) begin
        tag_type_select_reg <= nv_type;
      end
    end
  end

  // storage is touched only on the explicit save command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nv_save_req_reg <= 1'b0;
      nv_save_type_reg <= TYPE_DEFAULT;
    end else begin
      nv_save_req_reg <= wr_save;
      if (wr_save) begin
        nv_save_type_reg <= tag_type_select_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access error codes
  // read and write codes kept apart so one never hides the other

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_err_reg <= ACC_OK;
      write_err_reg <= ACC_OK;
      tag_err_reg <= TERR_NONE;
    end else if (acc_done) begin
      if (acc_is_write) begin
        write_err_reg <= outcome_code(acc_outcome);
      end else begin
        read_err_reg <= outcome_code(acc_outcome);
      end
      // a failed access, no answer or bad answer, leaves no tag code
      tag_err_reg <= (acc_outcome == OUTCOME_OK) ?
        tag_code_class(acc_tag_code) : TERR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // extended tag information, fetched on demand only

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_fetch_req_reg <= 1'b0;
      ext_pending_reg <= 1'b0;
    end else begin
      ext_fetch_req_reg <= wr_fetch;
      if (!present_next) begin
        ext_pending_reg <= 1'b0;
      end else if (wr_fetch) begin
        // a fresh request outranks the answer to the previous one
        ext_pending_reg <= 1'b1;
      end else if (ext_done) begin
        ext_pending_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_valid_reg <= 1'b0;
      ext_reg <= '0;
    end else if (!present_next) begin
      ext_valid_reg <= 1'b0;
      ext_reg <= '0;
    end else if (ext_done && ext_pending_reg) begin
      ext_valid_reg <= 1'b1;
      ext_reg <= ext_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // signal strength

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      signal_strength_level_reg <= LEVEL_NONE;
    end else if (!present_next) begin
      signal_strength_level_reg <= LEVEL_NONE;
    end else if ({4'h0, strength_raw} < LEVEL_MIN) begin
      // a detected tag never reports zero
      signal_strength_level_reg <= LEVEL_MIN;
    end else if ({4'h0, strength_raw} > LEVEL_MAX) begin
      // raw steps above the top of the scale are clipped, not wrapped
      signal_strength_level_reg <= LEVEL_MAX;
    end else begin
      signal_strength_level_reg <= {4'h0, strength_raw};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign od_ack = od_ack_reg;
  assign od_abort = od_abort_reg;
  assign od_rdata = od_rdata_reg;
  assign ext_fetch_req = ext_fetch_req_reg;
  assign field_on = antenna_enable_reg;
  assign access_type = tag_type_select_reg;
  assign nv_save_req = nv_save_req_reg;
  assign nv_save_type = nv_save_type_reg;

endmodule // rfid_head_objects

/* File: bench/rfid_head_partner.sv */
// front end model: transponder in the field and tag access engine
// assumes clk is the head clock; tasks are called by the bench
module rfid_head_partner (
  input wire logic clk, // head clock
  input wire logic ext_fetch_req, // fetch request from head
  output logic tag_seen, // tag in field
  output logic front_busy, // access running
  output logic acc_done, // access finished
  output logic acc_is_write, // finished access was a write
  output rfid_head_pkg::outcome_t acc_outcome, // access result
  output logic [7:0] acc_tag_code, // code sent by tag
  output logic [3:0] strength_raw, // raw level
  output logic [63:0] tag_uid, // uid of tag
  output logic ext_done, // extended info ready
  output logic [63:0] ext_data // extended info bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfid_head_pkg::*;
  int ext_delay = 2;
  int ext_cnt = 0;
  logic pending = 1'b0;
  logic [7:0] det_type = 8'h07;
  initial begin
    {tag_seen, front_busy, acc_done, acc_is_write, ext_done} = '0;
    acc_outcome = OUTCOME_OK;
    acc_tag_code = 8'h00;
    strength_raw = 4'h0;
    tag_uid = 64'h0;
    ext_data = 64'h0;
  end
  task automatic place(input logic [3:0] raw);
    @(posedge clk);
    tag_seen <= 1'b1;
    strength_raw <= raw;
    tag_uid <= 64'h0123456789ABCDEF;
  endtask
  // a tag leaving drives inverted strength and uid values instead of clearing them
  task automatic leave();
    @(posedge clk);
    tag_seen <= 1'b0;
    strength_raw <= ~strength_raw;
    tag_uid <= ~tag_uid;
  endtask
  task automatic access(input logic wr, input outcome_t oc,
                        input logic [7:0] code);
    @(posedge clk);
    front_busy <= 1'b1;
    acc_is_write <= wr;
    acc_outcome <= oc;
    acc_tag_code <= code;
    repeat (2) @(posedge clk);
    acc_done <= 1'b1;
    @(posedge clk);
    acc_done <= 1'b0;
    front_busy <= 1'b0;
    acc_tag_code <= ~code;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // answers a fetch only when asked, after ext_delay cycles
  always @(posedge clk) begin
    if (!ext_fetch_req && pending && ext_cnt == 0) begin
      pending <= 1'b0;
      ext_done <= 1'b1;
      ext_data <= {16'h5A5A, det_type, 40'h0102030405};
    end else begin
      ext_done <= 1'b0;
      ext_data <= ~ext_data;
      if (ext_fetch_req) begin
        pending <= 1'b1;
        ext_cnt <= ext_delay;
      end else if (pending) begin
        ext_cnt <= ext_cnt - 1;
      end
    end
  end
endmodule // rfid_head_partner

/* File: bench/rfid_head_objects_chk.sv */
// checker for the head object set: antenna, type, save, info, strength
// assumes it is bound to rfid_head_objects and sees its ports only
module rfid_head_objects_chk (
  input wire logic clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic od_req, // request
  input wire logic od_write, // write flag
  input wire logic [15:0] od_index, // index
  input wire logic [7:0] od_subindex, // sub-index
  input wire logic [31:0] od_wdata, // write value
  input wire logic od_abort, // refusal
  input wire logic [31:0] od_rdata, // read value
  input wire logic tag_seen, // tag detected
  input wire logic ext_fetch_req, // fetch pulse
  input wire logic field_on, // antenna on
  input wire logic [7:0] access_type, // selected type
  input wire logic nv_save_req, // save pulse
  input wire logic [7:0] nv_save_type // saved type
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfid_head_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wr, rd;
  assign wr = od_req & od_write;
  assign rd = od_req & ~od_write;
  chk_field_off: assert property (
    wr && od_index == IDX_ANTENNA_ENABLE && od_subindex == SUB_ZERO
    && od_wdata == 0
    |=> !field_on && !od_abort) else $error("field stays on");
  chk_field_on: assert property (
    wr && od_index == IDX_ANTENNA_ENABLE && od_subindex == SUB_ZERO
    && od_wdata == 1 |=> field_on)
    else $error("field stays off");
  chk_type_range: assert property (
    access_type >= TYPE_MIN && access_type <= TYPE_MAX)
    else $error("type out of range");
  chk_type_refuse: assert property (
    wr && od_index == IDX_TAG_TYPE_SELECT
    && (od_wdata == 0 || od_wdata > TYPE_MAX)
    |=> od_abort && $stable(access_type)) else $error("bad type taken");
  chk_save_cause: assert property (
    nv_save_req |-> $past(wr && od_index == IDX_SAVE_PARAM
    && od_wdata == SAVE_SIGNATURE)) else $error("save without trigger");
  chk_save_value: assert property (
    wr && od_index == IDX_SAVE_PARAM && od_subindex == SUB_SAVE_ALL
    && od_wdata == SAVE_SIGNATURE
    |=> nv_save_req && nv_save_type == access_type)
    else $error("save missing");
  chk_fetch_cause: assert property (
    ext_fetch_req |-> $past(wr && od_index == IDX_TAG_INFO_EXT))
    else $error("fetch without request");
  chk_info_empty: assert property (
    rd && od_index == IDX_TAG_INFO && od_subindex != SUB_ZERO
    && od_subindex <= SUB_LIST_LAST && !$past(tag_seen)
    |=> od_rdata == 0 && !od_abort) else $error("info without tag");
  chk_level_range: assert property (
    rd && od_index == IDX_SIGNAL_STRENGTH && od_subindex == SUB_ZERO
    |=> od_rdata <= {24'h0, LEVEL_MAX}) else $error("level too high");
endmodule // rfid_head_objects_chk
bind rfid_head_objects rfid_head_objects_chk u_chk (.clk(clk), .nrst(nrst),
  .od_req(od_req), .od_write(od_write), .od_index(od_index),
  .od_subindex(od_subindex), .od_wdata(od_wdata), .od_abort(od_abort),
  .od_rdata(od_rdata), .tag_seen(tag_seen), .ext_fetch_req(ext_fetch_req),
  .field_on(field_on), .access_type(access_type),
  .nv_save_req(nv_save_req), .nv_save_type(nv_save_type));

/* File: bench/rfid_head_objects_tb_top.sv */
// self-checking bench for the head object set
// assumes the front end model and the bound checker
module rfid_head_objects_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rfid_head_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic od_req = 1'b0, od_write = 1'b0, od_ack, od_abort;
  logic [15:0] od_index = 16'h0;
  logic [7:0] od_subindex = 8'h00;
  logic [31:0] od_wdata = 32'h0, od_rdata, rdv;
  logic nv_type_valid = 1'b0, nv_save_req, ext_fetch_req, field_on, abv;
  logic [7:0] nv_type = 8'h00, nv_save_type, access_type;
  logic tag_seen, front_busy, acc_done, acc_is_write, ext_done;
  outcome_t acc_outcome;
  logic [7:0] acc_tag_code;
  logic [3:0] strength_raw;
  logic [63:0] tag_uid, ext_data;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #5 clk = ~clk;
  rfid_head_partner u_fe (.*);
  rfid_head_objects #(.EXT_BYTES(8)) dut (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // answer comes exactly one edge after the request
  task automatic od(input logic wr, input logic [15:0] idx,
                    input logic [7:0] sub, input logic [31:0] wd);
    @(posedge clk);
    od_req <= 1'b1;
    od_write <= wr;
    od_index <= idx;
    od_subindex <= sub;
    od_wdata <= wd;
    @(posedge clk);
    od_req <= 1'b0;
    #1;
    check({7'h0, od_ack}, 8'h01);
    rdv = od_rdata;
    abv = od_abort;
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    od(0, IDX_DEVICE_STATUS, 8'h00, 0);
    check(rdv[7:0], 8'h03);
    check(rdv[31:24], 8'h00);
    od(0, IDX_TAG_TYPE_SELECT, 8'h00, 0);
    check(rdv[7:0], TYPE_DEFAULT);
    od(0, IDX_SIGNAL_STRENGTH, 8'h00, 0);
    check(rdv[7:0], LEVEL_NONE);
  endtask
  task automatic t_errors();
    logic [7:0] code [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'h10,
                              8'h11, 8'h12, 8'h13, 8'h14, 8'h05, 8'h20};
    for (int i = 0; i < 12; i++) begin
      u_fe.access(i[0], OUTCOME_OK, code[i]);
      od(0, IDX_DEVICE_STATUS, 8'h00, 0);
      check(rdv[31:24], i < 10 ? code[i] : TERR_OTHER);
      check(i[0] ? rdv[23:16] : rdv[15:8], ACC_OK);
    end
    u_fe.access(0, OUTCOME_NO_ANSWER, 8'h13);
    u_fe.access(1, OUTCOME_RX_FAULT, 8'h11);
    od(0, IDX_DEVICE_STATUS, 8'h00, 0);
    check(rdv[15:8], ACC_NO_ANSWER);
    check(rdv[23:16], ACC_RX_FAULT);
    check(rdv[31:24], TERR_NONE);
    u_fe.access(0, OUTCOME_RX_FAULT, 8'h00);
    u_fe.access(1, OUTCOME_NO_ANSWER, 8'h00);
    od(0, IDX_DEVICE_STATUS, 8'h00, 0);
    check(rdv[15:8], ACC_RX_FAULT);
    check(rdv[23:16], ACC_NO_ANSWER);
    // poll status while an access is still running
    fork
      u_fe.access(0, OUTCOME_OK, 8'h00);
      begin
        repeat (2) @(posedge clk);
        od(0, IDX_DEVICE_STATUS, 8'h00, 0);
      end
    join
    check(rdv[7:0], 8'h0B);
  endtask
  task automatic t_antenna();
    logic [3:0] raw [3] = '{4'h3, 4'h0, 4'hC};
    logic [7:0] lvl [3] = '{8'h03, 8'h01, 8'h08};
    for (int i = 0; i < 3; i++) begin
      u_fe.place(raw[i]);
      repeat (2) @(posedge clk);
      od(0, IDX_SIGNAL_STRENGTH, 8'h00, 0);
      check(rdv[7:0], lvl[i]);
    end
    od(1, IDX_ANTENNA_ENABLE, 8'h00, 0);
    check({7'h0, field_on}, 8'h00);
    repeat (2) @(posedge clk);
    od(0, IDX_SIGNAL_STRENGTH, 8'h00, 0);
    check(rdv[7:0], LEVEL_NONE);
    od(0, IDX_TAG_INFO, 8'h02, 0);
    check(rdv[7:0], 8'h00);
    od(0, IDX_DEVICE_STATUS, 8'h00, 0);
    check(rdv[7:0] & 8'h06, 8'h00);
    od(1, IDX_ANTENNA_ENABLE, 8'h00, 2);
    check({7'h0, abv}, 8'h01);
    od(1, IDX_ANTENNA_ENABLE, 8'h00, 1);
    check({7'h0, field_on}, 8'h01);
  endtask
  task automatic t_type();
    logic [7:0] sub [4] = '{8'h01, 8'h0D, 8'h0E, 8'hFE};
    logic [7:0] val [4] = '{8'h00, 8'h0E, 8'h0D, 8'h01};
    for (int i = 0; i < 4; i++) begin
      od(0, IDX_TAG_INFO, sub[i], 0);
      check(rdv[7:0], sub[i] <= TYPE_MAX ? sub[i] : 8'h00);
      od(1, IDX_TAG_TYPE_SELECT, 8'h00, {24'h0, val[i]});
      check({7'h0, abv}, {7'h0, i < 2});
      check(access_type, i < 2 ? TYPE_DEFAULT : val[i]);
    end
    od(0, IDX_TAG_INFO, SUB_ZERO, 0);
    check(rdv[7:0], SUB_LIST_LAST);
    od(0, IDX_TAG_INFO, 8'hFF, 0);
    check({7'h0, abv}, 8'h01);
    od(0, 16'h2170, 8'h00, 0);
    check({7'h0, abv}, 8'h01);
  endtask
  task automatic t_ext();
    u_fe.ext_delay = 20;
    od(1, IDX_TAG_INFO_EXT, 8'h00, 0);
    check({7'h0, ext_fetch_req}, 8'h01);
    od(0, IDX_TAG_INFO_EXT, 8'h06, 0);
    check(rdv[7:0], 8'h00);
    repeat (30) @(posedge clk);
    od(0, IDX_TAG_INFO_EXT, 8'h06, 0);
    check(rdv[7:0], 8'h07);
    od(1, IDX_TAG_TYPE_SELECT, 8'h00, rdv);
    check(access_type, 8'h07);
    od(0, IDX_UID_HIGH, 8'h00, 0);
    check(rdv[31:24], 8'h01);
    u_fe.leave();
    repeat (2) @(posedge clk);
    od(0, IDX_TAG_INFO_EXT, 8'h06, 0);
    check(rdv[7:0], 8'h00);
    od(0, IDX_TAG_INFO, 8'h01, 0);
    check(rdv[7:0], 8'h00);
    od(0, IDX_UID_LOW, 8'h00, 0);
    check(rdv[7:0], 8'h00);
    od(0, IDX_SIGNAL_STRENGTH, 8'h00, 0);
    check(rdv[7:0], LEVEL_NONE);
    od(1, IDX_TAG_INFO_EXT, 8'h00, 0);
    check({6'h0, ext_fetch_req, abv}, 8'h01);
  endtask
  task automatic t_save();
    od(1, IDX_SAVE_PARAM, SUB_SAVE_ALL, 32'h0);
    check({6'h0, abv, nv_save_req}, 8'h02);
    od(1, IDX_SAVE_PARAM, SUB_SAVE_ALL, SAVE_SIGNATURE);
    check({7'h0, nv_save_req}, 8'h01);
    check(nv_save_type, 8'h07);
    @(posedge clk);
    nv_type_valid <= 1'b1;
    nv_type <= 8'h07;
    do_reset();
    od(0, IDX_TAG_TYPE_SELECT, 8'h00, 0);
    check(rdv[7:0], 8'h07);
    @(posedge clk);
    nv_type <= 8'h0E;
    do_reset();
    od(0, IDX_TAG_TYPE_SELECT, 8'h00, 0);
    check(rdv[7:0], TYPE_DEFAULT);
  endtask
  initial begin
    do_reset();
    t_defaults();
    t_errors();
    t_antenna();
    t_type();
    t_ext();
    t_save();
    end_sim();
  end
endmodule // rfid_head_objects_tb_top
